// ===== clk_ratio_div.v
// Purpose: Divides the block clock by a programmable ratio into a one-cycle tick
// Assumes: Ratio is never zero; caller decodes zero codes
// Notes: Ratio one gives a tick on every edge, i.e. the source rate
module clk_ratio_div #(
    parameter W = 10
) (
    input wire i_clk,
    input wire i_rst_n,
    input wire i_en,
    input wire [W-1:0] i_ratio,
    output wire o_tick
);
    reg [W-1:0] cnt_q;
    reg tick_q;

    // Count to ratio-1; >= keeps a shrinking ratio from running away
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_q <= {W{1'b0}};
            tick_q <= 1'b0;
        end else if (!i_en) begin
            cnt_q <= {W{1'b0}};
            tick_q <= 1'b0;
        end else if (cnt_q >= i_ratio - {{(W-1){1'b0}}, 1'b1}) begin
            cnt_q <= {W{1'b0}};
            tick_q <= 1'b1;
        end else begin
            cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
            tick_q <= 1'b0;
        end
    end

    assign o_tick = tick_q;
endmodule // clk_ratio_div

// ===== clk_tree_cfg.v
// Purpose: Clock-tree configuration registers, ratio decode and dividers
// Assumes: Control port and auto-detect flag are synchronous to i_clk
// Notes: Ratios are registered one cycle after the storing write
`include "clk_tree_cfg_defines.vh"

module clk_tree_cfg (
    input wire i_clk,
    input wire i_rst_n,
    input wire i_wr_en,
    input wire i_rd_en,
    input wire [7:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_auto_detect,
    input wire [7:0] i_sec_bitclk_div_low,
    output wire [7:0] o_rdata,
    output wire o_rd_valid,
    output wire [13:0] o_frac_mult,
    output wire [8:0] o_int_mult,
    output wire o_pll_half_div,
    output wire [3:0] o_n_ratio,
    output wire [4:0] o_pdm_ratio,
    output wire [6:0] o_m_ratio,
    output wire [2:0] o_adc_mod_ratio,
    output wire [2:0] o_dac_mod_ratio,
    output wire [9:0] o_pri_bitclk_ratio,
    output wire [9:0] o_sec_bitclk_ratio,
    output wire o_code_error,
    output wire o_n_tick,
    output wire o_m_tick,
    output wire o_pdm_tick,
    output wire o_adc_mod_tick,
    output wire o_dac_mod_tick,
    output wire o_pri_bitclk_tick,
    output wire o_sec_bitclk_tick
);
    // Stored registers
    reg [7:0] mult_high_q;
    reg [7:0] frac_low_q;
    reg [7:0] int_low_q;
    reg [7:0] n_pdm_q;
    reg [7:0] m_adc_q;
    reg [7:0] dac_bclk_q;
    reg [7:0] pri_bclk_low_q;
    reg [7:0] div_en_q;
    reg [7:0] rdata_q;
    reg rd_valid_q;

    // Decoded ratios
    reg [13:0] frac_mult_d, frac_mult_q;
    reg [8:0] int_mult_d, int_mult_q;
    reg [3:0] n_ratio_d, n_ratio_q;
    reg [4:0] pdm_ratio_d, pdm_ratio_q;
    reg [6:0] m_ratio_d, m_ratio_q;
    reg [2:0] adc_ratio_d, adc_ratio_q;
    reg [2:0] dac_ratio_d, dac_ratio_q;
    reg [9:0] pri_ratio_d, pri_ratio_q;
    reg [9:0] sec_ratio_d, sec_ratio_q;
    reg code_err_d, code_err_q;
    reg half_div_q;

    // Raw fields
    wire [13:0] frac_code;
    wire [8:0] int_code;
    wire [2:0] n_code;
    wire [2:0] pdm_code;
    wire [5:0] m_code;
    wire [1:0] adc_code;
    wire [1:0] dac_code;
    wire [8:0] pri_code;
    wire [8:0] sec_code;

    assign frac_code = {mult_high_q[`FRAC_HIGH_MSB:`FRAC_HIGH_LSB], frac_low_q};
    assign int_code = {mult_high_q[`INT_HIGH_BIT], int_low_q};
    assign n_code = n_pdm_q[`N_DIV_MSB:`N_DIV_LSB];
    assign pdm_code = n_pdm_q[`PDM_CLOCK_DIVIDER_MSB:`PDM_CLOCK_DIVIDER_LSB];
    assign m_code = m_adc_q[`M_DIV_MSB:`M_DIV_LSB];
    assign adc_code = m_adc_q[`ADC_DIV_MSB:`ADC_DIV_LSB];
    assign dac_code = dac_bclk_q[`DAC_DIV_MSB:`DAC_DIV_LSB];
    assign pri_code = {dac_bclk_q[`PRI_BCLK_HIGH_BIT], pri_bclk_low_q};
    assign sec_code = {dac_bclk_q[`SEC_BCLK_HIGH_BIT], i_sec_bitclk_div_low};

    // Register writes; reserved R/W bits are stored as written, the host
    // keeps them at reset values, so nothing here masks them
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mult_high_q <= `PLL_MULT_HIGH_RST;
            frac_low_q <= `PLL_FRACTION_LOW_RST;
            int_low_q <= `PLL_INTEGER_LOW_RST;
            n_pdm_q <= `N_PDM_CLOCK_DIVIDER_RST;
            m_adc_q <= `M_ADC_DIV_RST;
            dac_bclk_q <= `DAC_BCLK_HIGH_RST;
            pri_bclk_low_q <= `PRI_BCLK_LOW_RST;
            div_en_q <= `DIV_ENABLE_RST;
        end else if (i_wr_en) begin
            case (i_addr)
                `PLL_MULT_HIGH_ADDR: mult_high_q <= i_wdata;
                `PLL_FRACTION_LOW_ADDR: frac_low_q <= i_wdata;
                `PLL_INTEGER_LOW_ADDR: int_low_q <= i_wdata;
                `N_PDM_CLOCK_DIVIDER_ADDR: n_pdm_q <= i_wdata;
                `M_ADC_DIV_ADDR: m_adc_q <= i_wdata;
                `DAC_BCLK_HIGH_ADDR: dac_bclk_q <= i_wdata & `DAC_BCLK_HIGH_WMASK;
                `PRI_BCLK_LOW_ADDR: pri_bclk_low_q <= i_wdata;
                `DIV_ENABLE_ADDR: div_en_q <= i_wdata & `DIV_ENABLE_WMASK;
                default: div_en_q <= div_en_q;
            endcase
        end
    end

    // Read port; unmapped offsets read zero, data one cycle after request
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rdata_q <= 8'h00;
            rd_valid_q <= 1'b0;
        end else begin
            rd_valid_q <= i_rd_en;
            if (i_rd_en) begin
                case (i_addr)
                    `PLL_MULT_HIGH_ADDR: rdata_q <= mult_high_q;
                    `PLL_FRACTION_LOW_ADDR: rdata_q <= frac_low_q;
                    `PLL_INTEGER_LOW_ADDR: rdata_q <= int_low_q;
                    `N_PDM_CLOCK_DIVIDER_ADDR: rdata_q <= n_pdm_q;
                    `M_ADC_DIV_ADDR: rdata_q <= m_adc_q;
                    `DAC_BCLK_HIGH_ADDR: rdata_q <= dac_bclk_q;
                    `PRI_BCLK_LOW_ADDR: rdata_q <= pri_bclk_low_q;
                    `DIV_ENABLE_ADDR: rdata_q <= div_en_q;
                    default: rdata_q <= 8'h00;
                endcase
            end
        end
    end

    // PLL multiplier decode and code check; reserved multiplier codes pass through; outside auto detect, reserved multiplier, PDM, ADC, DAC codes set the flag
    always @* begin
        frac_mult_d = frac_code;
        int_mult_d = int_code;
        code_err_d = 1'b0;
        if (frac_code > `FRAC_MAX) begin
            code_err_d = 1'b1;
        end
        if (int_code == 9'h000) begin
            code_err_d = 1'b1;
        end
        if (pdm_code > `PDM_CODE_MAX) begin
            code_err_d = 1'b1;
        end
        if (adc_code == `MOD_CODE_RSVD || dac_code == `MOD_CODE_RSVD) begin
            code_err_d = 1'b1;
        end
        if (i_auto_detect) begin
            code_err_d = 1'b0;
            frac_mult_d = 14'h0000;
            int_mult_d = `AUTO_INT_MULT;
        end
    end

    // Divider ratio decode; N, M and bit-clock zero codes map to the top ratio, PDM, ADC and DAC zero codes to one
    always @* begin
        n_ratio_d = (n_code == 3'h0) ? `N_ZERO_RATIO : {1'b0, n_code};
        m_ratio_d = (m_code == 6'h00) ? `M_ZERO_RATIO : {1'b0, m_code};
        pri_ratio_d = (pri_code == 9'h000) ? `BCLK_ZERO_RATIO : {1'b0, pri_code};
        sec_ratio_d = (sec_code == 9'h000) ? `BCLK_ZERO_RATIO : {1'b0, sec_code};
        case (pdm_code)
            3'h0: pdm_ratio_d = 5'h01;
            3'h1: pdm_ratio_d = 5'h02;
            3'h2: pdm_ratio_d = 5'h04;
            3'h3: pdm_ratio_d = 5'h08;
            3'h4: pdm_ratio_d = 5'h10;
            default: pdm_ratio_d = 5'h01; // Reserved: safest slow-free choice
        endcase
        case (adc_code)
            2'h0: adc_ratio_d = 3'h1;
            2'h1: adc_ratio_d = 3'h2;
            2'h2: adc_ratio_d = 3'h4;
            default: adc_ratio_d = 3'h1;
        endcase
        case (dac_code)
            2'h0: dac_ratio_d = 3'h1;
            2'h1: dac_ratio_d = 3'h2;
            2'h2: dac_ratio_d = 3'h4;
            default: dac_ratio_d = 3'h1;
        endcase
        // Auto detect derives its own ratios; unity stands in for them here
        if (i_auto_detect) begin
            n_ratio_d = 4'h1;
            m_ratio_d = 7'h01;
            pdm_ratio_d = 5'h01;
            adc_ratio_d = 3'h1;
            dac_ratio_d = 3'h1;
            pri_ratio_d = `RATIO_ONE;
            sec_ratio_d = `RATIO_ONE;
        end
    end

    // Register the decoded values so every output leaves a flip-flop
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            frac_mult_q <= 14'h0000;
            int_mult_q <= `AUTO_INT_MULT;
            n_ratio_q <= 4'h1;
            pdm_ratio_q <= 5'h01;
            m_ratio_q <= 7'h01;
            adc_ratio_q <= 3'h1;
            dac_ratio_q <= 3'h1;
            pri_ratio_q <= `RATIO_ONE;
            sec_ratio_q <= `RATIO_ONE;
            code_err_q <= 1'b0;
            half_div_q <= 1'b0;
        end else begin
            frac_mult_q <= frac_mult_d;
            int_mult_q <= int_mult_d;
            n_ratio_q <= n_ratio_d;
            pdm_ratio_q <= pdm_ratio_d;
            m_ratio_q <= m_ratio_d;
            adc_ratio_q <= adc_ratio_d;
            dac_ratio_q <= dac_ratio_d;
            pri_ratio_q <= pri_ratio_d;
            sec_ratio_q <= sec_ratio_d;
            code_err_q <= code_err_d;
            half_div_q <= mult_high_q[`PLL_HALF_BIT];
        end
    end

    // Dividers; only N, M and PDM have enables in this slice
    clk_ratio_div #(.W(4)) u_n_div (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_en(div_en_q[`N_EN_BIT]),
        .i_ratio(n_ratio_q),
        .o_tick(o_n_tick)
    );

    clk_ratio_div #(.W(7)) u_m_div (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_en(div_en_q[`M_EN_BIT]),
        .i_ratio(m_ratio_q),
        .o_tick(o_m_tick)
    );

    clk_ratio_div #(.W(5)) u_pdm_clock_divider (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_en(div_en_q[`PDM_EN_BIT]),
        .i_ratio(pdm_ratio_q),
        .o_tick(o_pdm_tick)
    );

    clk_ratio_div #(.W(3)) u_adc_div (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_en(1'b1),
        .i_ratio(adc_ratio_q),
        .o_tick(o_adc_mod_tick)
    );

    clk_ratio_div #(.W(3)) u_dac_div (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_en(1'b1),
        .i_ratio(dac_ratio_q),
        .o_tick(o_dac_mod_tick)
    );

    clk_ratio_div #(.W(10)) u_pri_div (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_en(1'b1),
        .i_ratio(pri_ratio_q),
        .o_tick(o_pri_bitclk_tick)
    );

    clk_ratio_div #(.W(10)) u_sec_div (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_en(1'b1),
        .i_ratio(sec_ratio_q),
        .o_tick(o_sec_bitclk_tick)
    );

    // Outputs straight from flip-flops
    assign o_rdata = rdata_q;
    assign o_rd_valid = rd_valid_q;
    assign o_frac_mult = frac_mult_q;
    assign o_int_mult = int_mult_q;
    assign o_pll_half_div = half_div_q;
    assign o_n_ratio = n_ratio_q;
    assign o_pdm_ratio = pdm_ratio_q;
    assign o_m_ratio = m_ratio_q;
    assign o_adc_mod_ratio = adc_ratio_q;
    assign o_dac_mod_ratio = dac_ratio_q;
    assign o_pri_bitclk_ratio = pri_ratio_q;
    assign o_sec_bitclk_ratio = sec_ratio_q;
    assign o_code_error = code_err_q;
endmodule // clk_tree_cfg

// ===== clk_tree_cfg_defines.vh
// Purpose: Offsets, field positions, reset values and limits for the clock-tree slice
// Assumes: 8-bit control port, byte-wide registers
// Notes: Included by clk_tree_cfg.v only
`ifndef CLK_TREE_CFG_DEFINES_VH
`define CLK_TREE_CFG_DEFINES_VH

// Register offsets
`define PLL_MULT_HIGH_ADDR 8'h36
`define PLL_FRACTION_LOW_ADDR 8'h37
`define PLL_INTEGER_LOW_ADDR 8'h38
`define N_PDM_CLOCK_DIVIDER_ADDR 8'h39
`define M_ADC_DIV_ADDR 8'h3a
`define DAC_BCLK_HIGH_ADDR 8'h3b
`define PRI_BCLK_LOW_ADDR 8'h3c
`define DIV_ENABLE_ADDR 8'h44

// Reset values
`define PLL_MULT_HIGH_RST 8'h00
`define PLL_FRACTION_LOW_RST 8'h00
`define PLL_INTEGER_LOW_RST 8'h08
`define N_PDM_CLOCK_DIVIDER_RST 8'h20
`define M_ADC_DIV_RST 8'h04
`define DAC_BCLK_HIGH_RST 8'h00
`define PRI_BCLK_LOW_RST 8'h01
`define DIV_ENABLE_RST 8'h00

// Writable bit masks; read-only reserved bits read zero
`define DAC_BCLK_HIGH_WMASK 8'hfe
`define DIV_ENABLE_WMASK 8'h07

// Field positions
`define FRAC_HIGH_MSB 5
`define FRAC_HIGH_LSB 0
`define INT_HIGH_BIT 7
`define PLL_HALF_BIT 6
`define N_DIV_MSB 7
`define N_DIV_LSB 5
`define PDM_CLOCK_DIVIDER_MSB 4
`define PDM_CLOCK_DIVIDER_LSB 2
`define M_DIV_MSB 7
`define M_DIV_LSB 2
`define ADC_DIV_MSB 1
`define ADC_DIV_LSB 0
`define DAC_DIV_MSB 5
`define DAC_DIV_LSB 4
`define PRI_BCLK_HIGH_BIT 2
`define SEC_BCLK_HIGH_BIT 1
`define N_EN_BIT 2
`define M_EN_BIT 1
`define PDM_EN_BIT 0

// Code limits and decoded values
`define FRAC_MAX 14'h270f
`define PDM_CODE_MAX 3'h4
`define MOD_CODE_RSVD 2'h3
`define N_ZERO_RATIO 4'h8
`define M_ZERO_RATIO 7'h40
`define BCLK_ZERO_RATIO 10'h200
`define AUTO_INT_MULT 9'h008
`define RATIO_ONE 10'h001

`endif

// ===== clk_tree_cfg_monitor.sv
// Purpose: Port-level checks on the clock-tree slice
// Assumes: One clock, async active-low reset
// Notes: Ratios land two edges after the storing write
module clk_tree_cfg_monitor (
    input wire i_clk,
    input wire i_rst_n,
    input wire i_wr_en,
    input wire [7:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_auto_detect,
    input wire [13:0] o_frac_mult,
    input wire [8:0] o_int_mult,
    input wire [3:0] o_n_ratio,
    input wire [4:0] o_pdm_ratio,
    input wire [6:0] o_m_ratio,
    input wire [2:0] o_adc_mod_ratio,
    input wire [2:0] o_dac_mod_ratio,
    input wire o_code_error,
    input wire o_n_tick,
    input wire o_adc_mod_tick,
    input wire o_dac_mod_tick
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    // Writes other than to 8'h44 only count while programmed values are honoured
    wire man = !i_auto_detect;
    wire w37 = i_wr_en && i_addr == 8'h37 && man;
    wire w38 = i_wr_en && i_addr == 8'h38 && man;
    wire w39 = i_wr_en && i_addr == 8'h39 && man;
    wire w3a = i_wr_en && i_addr == 8'h3a && man;
    wire w44 = i_wr_en && i_addr == 8'h44;
    // Decode of the N, PDM, M and ADC fields and the low multiplier bytes from the byte written two edges back
    n_decode_a: assert property (w39 ##1 man |=> o_n_ratio ==
        ($past(i_wdata[7:5], 2) == 3'h0 ? 4'h8 : {1'b0, $past(i_wdata[7:5], 2)}))
        else $error("n ratio decode wrong");
    pdm_decode_a: assert property (w39 ##1 man |=> o_pdm_ratio ==
        ($past(i_wdata[4:2], 2) > 3'h4 ? 5'h01 : 5'h01 << $past(i_wdata[4:2], 2)))
        else $error("pdm ratio decode wrong");
    m_adc_decode_a: assert property (w3a ##1 man |=>
        o_m_ratio == ($past(i_wdata[7:2], 2) == 6'h00 ? 7'h40 : {1'b0, $past(i_wdata[7:2], 2)})
        && o_adc_mod_ratio == ($past(i_wdata[1:0], 2) == 2'h3 ? 3'h1
        : 3'h1 << $past(i_wdata[1:0], 2))) else $error("m or adc ratio decode wrong");
    int_join_a: assert property (w38 ##1 man |=> o_int_mult[7:0] == $past(i_wdata, 2))
        else $error("integer low byte not joined");
    frac_join_a: assert property (w37 ##1 man |=> o_frac_mult[7:0] == $past(i_wdata, 2))
        else $error("fraction low byte not joined");
    // Auto detection hides the programmed multiplier and N ratio and clears the code error
    auto_override_a: assert property (i_auto_detect [*2] |-> o_int_mult == 9'h008
        && o_frac_mult == 14'h0000 && o_n_ratio == 4'h1 && !o_code_error)
        else $error("auto detect did not override");
    // Ratio one passes the clock, ratio two alternates
    adc_pass_a: assert property ((o_adc_mod_ratio == 3'h1) [*2] |-> o_adc_mod_tick)
        else $error("ratio one did not pass clock");
    dac_period_a: assert property ((o_dac_mod_ratio == 3'h2) [*6] ##0 o_dac_mod_tick
        |-> !$past(o_dac_mod_tick) && $past(o_dac_mod_tick, 2)) else $error("dac period wrong");
    n_disable_a: assert property (w44 && !i_wdata[2] ##1 !w44 |=> !o_n_tick)
        else $error("disabled n divider ticked");
    cover property (w39);
    cover property (o_code_error);
    cover property (i_auto_detect [*2]);
endmodule // clk_tree_cfg_monitor

bind clk_tree_cfg clk_tree_cfg_monitor u_mon (.i_clk, .i_rst_n, .i_wr_en, .i_addr, .i_wdata,
    .i_auto_detect, .o_frac_mult, .o_int_mult, .o_n_ratio, .o_pdm_ratio, .o_m_ratio,
    .o_adc_mod_ratio, .o_dac_mod_ratio, .o_code_error, .o_n_tick, .o_adc_mod_tick,
    .o_dac_mod_tick);

// ===== clk_tree_cfg_test.sv
// Purpose: Self-checking bench for the clock-tree slice
// Assumes: Host model drives the control port
// Notes: Reads are checked in arrival order from a queue
module clk_tree_cfg_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic auto_on = 1'b0;
    logic [7:0] sec_low = 8'h00;
    logic [7:0] e, b;
    logic [5:0] m;
    logic [13:0] f;
    logic [8:0] j;
    logic [7:0] exp_q[$];
    logic [7:0] ra[9] = '{8'h36, 8'h37, 8'h38, 8'h39, 8'h3a, 8'h3b, 8'h3c, 8'h44, 8'h50};
    logic [7:0] rv[9] = '{8'h00, 8'h00, 8'h08, 8'h20, 8'h04, 8'h00, 8'h01, 8'h00, 8'h00};
    int fr[3] = '{9999, 10000, 0};
    int jr[3] = '{511, 1, 0};
    int fail_count = 0;
    int check_count = 0;
    int cycles = 0;
    int seed = 32'h4d83;
    int i, nt, mt, pt, qt, st;
    wire wr_en, rd_en, rd_valid, code_err, n_tick, m_tick, pdm_tick;
    wire half_div, pri_tick, sec_tick;
    wire [7:0] addr, wdata, rdata;
    wire [13:0] frac;
    wire [8:0] int_m;
    wire [3:0] n_r;
    wire [4:0] pdm_r;
    wire [6:0] m_r;
    wire [2:0] adc_r, dac_r;
    wire [9:0] pri_r, sec_r;
    always #2.5 clk = ~clk;
    host_ctl_model host (.i_clk(clk), .o_wr_en(wr_en), .o_rd_en(rd_en), .o_addr(addr),
        .o_wdata(wdata));
    clk_tree_cfg u_clk_tree_cfg (.i_clk(clk), .i_rst_n(rst_n), .i_wr_en(wr_en),
        .i_rd_en(rd_en), .i_addr(addr), .i_wdata(wdata), .i_auto_detect(auto_on),
        .i_sec_bitclk_div_low(sec_low), .o_rdata(rdata), .o_rd_valid(rd_valid),
        .o_frac_mult(frac), .o_int_mult(int_m), .o_pll_half_div(half_div), .o_n_ratio(n_r),
        .o_pdm_ratio(pdm_r), .o_m_ratio(m_r), .o_adc_mod_ratio(adc_r), .o_dac_mod_ratio(dac_r),
        .o_pri_bitclk_ratio(pri_r), .o_sec_bitclk_ratio(sec_r), .o_code_error(code_err),
        .o_n_tick(n_tick), .o_m_tick(m_tick), .o_pdm_tick(pdm_tick), .o_adc_mod_tick(),
        .o_dac_mod_tick(), .o_pri_bitclk_tick(pri_tick), .o_sec_bitclk_tick(sec_tick));
    // Level compare; an unknown bit matches only an unknown expected bit
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] x);
        exp_q.push_back(x);
        host.xfer(1'b0, 1'b1, a, 8'h00);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.xfer(1'b1, 1'b0, a, d);
    endtask
    task automatic idle(input int n);
        repeat (n) host.xfer(1'b0, 1'b0, 8'h00, 8'h00);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Read watcher, tick counters and hang guard
    always @(posedge clk) begin
        cycles++;
        nt += (n_tick === 1'b1);
        mt += (m_tick === 1'b1);
        pt += (pdm_tick === 1'b1);
        qt += (pri_tick === 1'b1);
        st += (sec_tick === 1'b1);
        if (rd_valid === 1'b1) begin
            e = (exp_q.size() != 0) ? exp_q.pop_front() : 8'hxx;
            chk(rdata, e);
        end
        if (cycles == 2000) begin
            fail_count++;
            finish_test();
        end
    end
    initial begin
        repeat (6) @(posedge clk);
        #1;
        rst_n = 1'b1;
        idle(2);
        chk({n_r, m_r, int_m}, {4'h1, 7'h01, 9'h008});
        chk(pri_r, 10'h001);
        chk(frac, 14'h0000);
        for (i = 0; i < 9; i++) rd(ra[i], rv[i]);
        $display("reset values done");
        for (i = 0; i < 8; i++) begin
            wr(8'h39, {i[2:0], i[2:0], 2'b00});
            idle(2);
            chk(n_r, i == 0 ? 4'h8 : i);
            chk(pdm_r, i > 4 ? 5'h01 : 5'h01 << i);
            chk(code_err, i > 4);
        end
        wr(8'h39, 8'h20);
        for (i = 0; i < 8; i++) begin
            m = (i < 2) ? i : ((i == 2) ? 6'h3f : $random(seed));
            wr(8'h3a, {m, i[1:0]});
            idle(2);
            chk(m_r, m == 0 ? 7'h40 : m);
            chk(adc_r, i[1:0] == 3 ? 3'h1 : 3'h1 << i[1:0]);
            chk(code_err, i[1:0] == 3);
            rd(8'h3a, {m, i[1:0]});
        end
        wr(8'h3a, 8'h04);
        $display("n m pdm adc decode done");
        for (i = 0; i < 4; i++) begin
            b = (i == 0) ? 8'h00 : $random(seed);
            sec_low = i[0] ? ~b : b;
            wr(8'h3b, {2'b00, i[1:0], 1'b0, i[0], i[1], 1'b0});
            wr(8'h3c, b);
            idle(2);
            chk(dac_r, i == 3 ? 3'h1 : 3'h1 << i);
            chk(pri_r, {i[0], b} == 0 ? 10'h200 : {i[0], b});
            chk(sec_r, {i[1], sec_low} == 0 ? 10'h200 : {i[1], sec_low});
            rd(8'h3b, {2'b00, i[1:0], 1'b0, i[0], i[1], 1'b0});
        end
        wr(8'h3b, 8'h00);
        $display("dac and bit clock done");
        for (i = 0; i < 3; i++) begin
            f = fr[i];
            j = jr[i];
            wr(8'h36, {j[8], i[0], f[13:8]});
            wr(8'h37, f[7:0]);
            wr(8'h38, j[7:0]);
            idle(2);
            chk(frac, f);
            chk(int_m, j);
            chk(code_err, i > 0);
            chk(half_div, i[0]);
        end
        wr(8'h39, 8'ha0);
        auto_on = 1'b1;
        idle(3);
        chk({int_m, frac, n_r}, {9'h008, 14'h0000, 4'h1});
        chk({code_err, pri_r}, 11'h001);
        auto_on = 1'b0;
        wr(8'h38, 8'h08);
        $display("pll multiplier and auto done");
        sec_low = 8'h08;
        wr(8'h39, 8'h68);
        wr(8'h3a, 8'h08);
        wr(8'h3b, 8'h10);
        wr(8'h3c, 8'h06);
        wr(8'h44, 8'h07);
        idle(3);
        {nt, mt, pt, qt, st} = 0;
        idle(24);
        chk(nt, 8);
        chk(mt, 12);
        chk(pt, 6);
        chk(qt, 4);
        chk(st, 3);
        wr(8'h44, 8'h00);
        idle(2);
        {nt, mt, pt} = 0;
        idle(24);
        chk(nt + mt + pt, 0);
        rd(8'h44, 8'h00);
        idle(2);
        chk(exp_q.size(), 0);
        $display("dividers done");
        finish_test();
    end
endmodule // clk_tree_cfg_test

// ===== host_ctl_model.sv
// Purpose: Host side of the control port, one access per edge
// Assumes: Tasks are entered just after a rising edge
// Notes: Signals hold until the next call, so calls may run back to back
module host_ctl_model (
    input wire i_clk,
    output logic o_wr_en,
    output logic o_rd_en,
    output logic [7:0] o_addr,
    output logic [7:0] o_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {o_wr_en, o_rd_en, o_addr, o_wdata} = 18'h0_0000;
    end
    // Present an access, let the taking edge pass
    task automatic xfer(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        o_wr_en = w;
        o_rd_en = r;
        o_addr = a;
        // Reserved fields always get their reset value
        case (a)
            8'h39: o_wdata = d & 8'hfc;
            8'h3b: o_wdata = d & 8'h36;
            8'h44: o_wdata = d & 8'h07;
            default: o_wdata = d;
        endcase
        @(posedge i_clk);
        #1;
    endtask
endmodule // host_ctl_model
